// file: common/lvm_pkg.sv
package lvm_pkg;

    localparam logic [0:0] ADDR_POWER_MONITOR_CONTROL = 1'h0;
    localparam logic [0:0] ADDR_STOP_POWER_STATUS_CONTROL = 1'h1;

    // Bit positions, power_monitor_control
    localparam int WARN_FLAG_BIT = 7;
    localparam int WARN_ACK_BIT = 6;
    localparam int WARN_IE_BIT = 5;
    localparam int DET_RESET_EN_BIT = 4;
    localparam int DET_STOP_EN_BIT = 3;
    localparam int DET_EN_BIT = 2;
    localparam int BANDGAP_EN_BIT = 0;

    // Bit positions, stop_power_status_control
    localparam int DET_VSEL_BIT = 5;
    localparam int WARN_VSEL_BIT = 4;
    localparam int PPD_FLAG_BIT = 3;
    localparam int PPD_ACK_BIT = 2;
    localparam int PPD_CTRL_BIT = 0;

    localparam logic [7:0] PMC_RESET = 8'h1C;
    localparam logic [7:0] SPSC_RESET = 8'h00;

    typedef struct packed {
        logic warning_interrupt_enable;
        logic detect_reset_enable;
        logic detect_stop_enable;
        logic detect_enable;
        logic bandgap_buffer_enable;
        logic detect_voltage_select;
        logic warning_voltage_select;
        logic partial_power_down_control;
    } ctrl_s;

    typedef struct packed {
        logic pmc_reset_enable;
        logic pmc_detect_enable;
        logic spsc_detect_vsel;
        logic spsc_ppd_ctrl;
    } lock_s;

endpackage

// file: core/low_voltage_monitor_control.sv
`timescale 1ns/1ns
// Overview of operation
// - Warning flag sets on supply below warning point; stays set afterward.
// - Warning acknowledge clears flag only if warning condition has gone.
// - Interrupt requested while flag set and warning interrupt enable is one.
// - Detect event forces reset when detect reset and detect enables are one, and in stop mode only with detect stop enable.
// - Detect stop enable keeps detection running in stop mode.
// - Detect enable gates detect logic and qualifies reset/stop enables.
// - Bandgap buffer enable bit drives the reference buffer enable.
// - Write-once bits accept only the first write after reset; detect voltage select only the first write after power-on reset.
// - Detect and warning voltage selects form a two-bit trip code.
// - Partial power-down flag sets on recovery from stop2.
// - Writing one to partial power-down acknowledge clears the flag.
// - Partial power-down control picks stop2 (one) or stop3 (zero).
// - Detect voltage select re-arms only on power-on reset.
module low_voltage_monitor_control
    import lvm_pkg::*;
(
    input wire logic core_clk,        // 20 MHz bus clock
    input wire logic rst,             // Async reset, active high
    input wire logic por,             // Power-on reset, async, active high
    input wire logic [0:0] reg_addr,  // Register select
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr,          // Write strobe
    input wire logic reg_rd,          // Read strobe
    output logic [7:0] reg_rdata,     // Read data, cycle after strobe
    input wire logic warn_cmp,        // Analog: supply below warning point
    input wire logic detect_cmp,      // Analog: supply below detect point
    input wire logic stop_active,     // Device is in stop mode
    input wire logic stop2_recovered, // One-cycle pulse: woke from stop2
    output logic irq,                 // Level interrupt
    output logic detect_reset_req,    // Request for device reset
    output logic detect_active,       // Detect comparator powered
    output logic bandgap_buf_en,      // Bandgap buffer enable
    output logic [1:0] trip_code,     // Detect:warning voltage code
    output logic stop2_select         // Stop request enters stop2
);
    ctrl_s ctrl;
    ctrl_s next_ctrl;
    lock_s lock;
    lock_s next_lock;
    logic por_lock;
    logic next_por_lock;
    logic warning_status_flag;
    logic next_warning_status_flag;
    logic partial_power_down_flag;
    logic next_partial_power_down_flag;
    logic [7:0] next_reg_rdata;
    logic next_detect_reset_req;
    logic warn_s;
    logic detect_s;
    logic wr_pmc;
    logic wr_spsc;
    logic detect_vsel_q;
    logic next_detect_vsel;

    // One decode point, so writes and reads can never disagree on the map
    function automatic logic addr_is_pmc(input logic [0:0] addr);
        return addr == ADDR_POWER_MONITOR_CONTROL;
    endfunction

    sync2 u_warn_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(warn_cmp),
        .sync_out(warn_s)
    );
    sync2 u_det_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(detect_cmp),
        .sync_out(detect_s)
    );

    assign wr_pmc = reg_wr && addr_is_pmc(reg_addr);
    assign wr_spsc = reg_wr && !addr_is_pmc(reg_addr);

    always_comb begin
        next_ctrl = ctrl;
        next_lock = lock;
        next_por_lock = por_lock;
        next_detect_vsel = detect_vsel_q;
        next_warning_status_flag = warning_status_flag;
        next_partial_power_down_flag = partial_power_down_flag;
        if (wr_pmc) begin
            next_ctrl.warning_interrupt_enable = reg_wdata[WARN_IE_BIT];
            next_ctrl.detect_stop_enable = reg_wdata[DET_STOP_EN_BIT];
            next_ctrl.bandgap_buffer_enable = reg_wdata[BANDGAP_EN_BIT];
            if (!lock.pmc_reset_enable) begin
                next_ctrl.detect_reset_enable = reg_wdata[DET_RESET_EN_BIT];
                next_lock.pmc_reset_enable = 1'b1;
            end
            if (!lock.pmc_detect_enable) begin
                next_ctrl.detect_enable = reg_wdata[DET_EN_BIT];
                next_lock.pmc_detect_enable = 1'b1;
            end
        end
        if (wr_spsc) begin
            next_ctrl.warning_voltage_select = reg_wdata[WARN_VSEL_BIT];
            if (!por_lock) begin
                next_detect_vsel = reg_wdata[DET_VSEL_BIT];
                next_por_lock = 1'b1;
            end
            if (!lock.spsc_ppd_ctrl) begin
                next_ctrl.partial_power_down_control = reg_wdata[PPD_CTRL_BIT];
                next_lock.spsc_ppd_ctrl = 1'b1;
            end
        end
        if (wr_pmc && reg_wdata[WARN_ACK_BIT] && !warn_s) begin
            next_warning_status_flag = 1'b0;
        end
        if (warn_s) begin
            next_warning_status_flag = 1'b1;
        end
        if (wr_spsc && reg_wdata[PPD_ACK_BIT]) begin
            next_partial_power_down_flag = 1'b0;
        end
        if (stop2_recovered) begin
            next_partial_power_down_flag = 1'b1;
        end
        // Mirror only; the power-on copy is the one that is read
        next_ctrl.detect_voltage_select = next_detect_vsel;
    end

    // Detect voltage select held apart so only power-on reset clears it
    always_ff @(posedge core_clk or posedge por) begin
        if (por) begin
            por_lock <= 1'b0;
            detect_vsel_q <= 1'b0;
        end else begin
            por_lock <= next_por_lock;
            detect_vsel_q <= next_detect_vsel;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl <= '{default: 1'b0};
            ctrl.detect_reset_enable <= PMC_RESET[DET_RESET_EN_BIT];
            ctrl.detect_stop_enable <= PMC_RESET[DET_STOP_EN_BIT];
            ctrl.detect_enable <= PMC_RESET[DET_EN_BIT];
            lock <= '0;
            warning_status_flag <= 1'b0;
            partial_power_down_flag <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            lock <= next_lock;
            warning_status_flag <= next_warning_status_flag;
            partial_power_down_flag <= next_partial_power_down_flag;
        end
    end

    assign trip_code = {detect_vsel_q, ctrl.warning_voltage_select};
    assign bandgap_buf_en = ctrl.bandgap_buffer_enable;
    assign stop2_select = ctrl.partial_power_down_control;
    assign detect_active = ctrl.detect_enable && (!stop_active || ctrl.detect_stop_enable);
    assign irq = ctrl.warning_interrupt_enable && warning_status_flag;

    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            if (addr_is_pmc(reg_addr)) begin
                next_reg_rdata[WARN_FLAG_BIT] = warning_status_flag;
                next_reg_rdata[WARN_IE_BIT] = ctrl.warning_interrupt_enable;
                next_reg_rdata[DET_RESET_EN_BIT] = ctrl.detect_reset_enable;
                next_reg_rdata[DET_STOP_EN_BIT] = ctrl.detect_stop_enable;
                next_reg_rdata[DET_EN_BIT] = ctrl.detect_enable;
                next_reg_rdata[BANDGAP_EN_BIT] = ctrl.bandgap_buffer_enable;
            end else begin
                next_reg_rdata[DET_VSEL_BIT] = detect_vsel_q;
                next_reg_rdata[WARN_VSEL_BIT] = ctrl.warning_voltage_select;
                next_reg_rdata[PPD_FLAG_BIT] = partial_power_down_flag;
                next_reg_rdata[PPD_CTRL_BIT] = ctrl.partial_power_down_control;
            end
        end
        // detect forces reset; only with detect enabled
        next_detect_reset_req = detect_s && ctrl.detect_enable
            && ctrl.detect_reset_enable && detect_active;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            detect_reset_req <= 1'b0;
        end else begin
            reg_rdata <= next_reg_rdata;
            detect_reset_req <= next_detect_reset_req;
        end
    end

    warn_sets_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        warn_s |=> warning_status_flag)
        else $error("warning flag not set");

    ack_blocked_a: assert property (@(posedge core_clk) disable iff (rst)
        warning_status_flag && warn_s |=> warning_status_flag)
        else $error("warning flag cleared under warning");

    irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        irq == (warning_status_flag && ctrl.warning_interrupt_enable))
        else $error("interrupt level wrong");

    reset_req_a: assert property (@(posedge core_clk) disable iff (rst)
        detect_reset_req |-> $past(ctrl.detect_reset_enable) && $past(detect_s))
        else $error("reset request without cause");

    stop_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        stop_active && !ctrl.detect_stop_enable |-> !detect_active)
        else $error("detect active in stop");

    detect_off_a: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl.detect_enable |=> !detect_reset_req)
        else $error("reset with detect disabled");

    once_lock_a: assert property (@(posedge core_clk) disable iff (rst)
        lock.spsc_ppd_ctrl ##1 lock.spsc_ppd_ctrl |-> $stable(stop2_select))
        else $error("write-once bit changed");

    ppd_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        stop2_recovered |=> partial_power_down_flag)
        else $error("partial power-down flag not set");

    // Named conditions, four single-cycle and two over two cycles; the properties below are built on them
    sequence ie_set_under_warning;
        wr_pmc && reg_wdata[WARN_IE_BIT] && warn_s;
    endsequence

    sequence ack_after_warning;
        wr_pmc && reg_wdata[WARN_ACK_BIT] && !warn_s;
    endsequence

    sequence ppd_ack_alone;
        wr_spsc && reg_wdata[PPD_ACK_BIT] && !stop2_recovered;
    endsequence

    sequence armed_detect_event;
        detect_s && ctrl.detect_enable && ctrl.detect_reset_enable && !stop_active;
    endsequence

    sequence vsel_locked_twice;
        por_lock ##1 por_lock;
    endsequence

    sequence detect_en_locked_twice;
        lock.pmc_detect_enable ##1 lock.pmc_detect_enable;
    endsequence

    irq_path_a: assert property (@(posedge core_clk) disable iff (rst)
        ie_set_under_warning |=> irq)
        else $error("interrupt not raised");

    ack_clears_a: assert property (@(posedge core_clk) disable iff (rst)
        ack_after_warning |=> !warning_status_flag)
        else $error("warning flag not cleared");

    ppd_ack_a: assert property (@(posedge core_clk) disable iff (rst)
        ppd_ack_alone |=> !partial_power_down_flag)
        else $error("partial power-down flag not cleared");

    reset_follows_a: assert property (@(posedge core_clk) disable iff (rst)
        armed_detect_event |=> detect_reset_req)
        else $error("detect event gave no reset request");

    // select survives reset; ordinary reset is not a disable here on purpose
    vsel_lock_a: assert property (@(posedge core_clk) disable iff (por)
        vsel_locked_twice |-> $stable(detect_vsel_q))
        else $error("detect voltage select changed after lock");

    detect_lock_a: assert property (@(posedge core_clk) disable iff (rst)
        detect_en_locked_twice |-> $stable(ctrl.detect_enable))
        else $error("detect enable changed after lock");

    bandgap_write_a: assert property (@(posedge core_clk) disable iff (rst)
        wr_pmc |=> bandgap_buf_en == $past(reg_wdata[BANDGAP_EN_BIT]))
        else $error("bandgap buffer enable not written");

    warn_vsel_a: assert property (@(posedge core_clk) disable iff (rst)
        wr_spsc |=> trip_code[0] == $past(reg_wdata[WARN_VSEL_BIT]))
        else $error("warning voltage select not written");

    stop_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        wr_spsc && !lock.spsc_ppd_ctrl |=> stop2_select == $past(reg_wdata[PPD_CTRL_BIT]))
        else $error("stop mode choice not written");

    // a rise must trail the comparator by both flops, never skip one
    sync_warn_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(warn_s) |-> $past(warn_cmp, 2))
        else $error("warning comparator not synchronised");

    sync_detect_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(detect_s) |-> $past(detect_cmp, 2))
        else $error("detect comparator not synchronised");
endmodule

// file: core/sync2.sv
`timescale 1ns/1ns
module sync2 (
    input wire logic core_clk, // Bus clock
    input wire logic rst,      // Async reset
    input wire logic async_in, // Level from outside the clock domain
    output logic sync_out      // Synchronised level
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// file: verif/test_low_voltage_monitor_control.sv
`timescale 1ns/1ns
module test_low_voltage_monitor_control;
    import lvm_pkg::*;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic [0:0] reg_addr = 1'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic warn_cmp = 1'b0;
    logic detect_cmp = 1'b0;
    logic stop_active = 1'b0;
    logic stop2_recovered = 1'b0;
    logic irq;
    logic detect_reset_req;
    logic detect_active;
    logic bandgap_buf_en;
    logic [1:0] trip_code;
    logic stop2_select;
    int fail_count = 0;
    int checks_done = 0;
    logic [7:0] rdat;

    always #25 core_clk = ~core_clk;

    low_voltage_monitor_control dut (
        .core_clk(core_clk),
        .rst(rst),
        .por(por),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .warn_cmp(warn_cmp),
        .detect_cmp(detect_cmp),
        .stop_active(stop_active),
        .stop2_recovered(stop2_recovered),
        .irq(irq),
        .detect_reset_req(detect_reset_req),
        .detect_active(detect_active),
        .bandgap_buf_en(bandgap_buf_en),
        .trip_code(trip_code),
        .stop2_select(stop2_select)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [0:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [0:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask

    // Power-on reset always comes with the ordinary reset
    task automatic do_reset(input logic with_por);
        @(posedge core_clk);
        rst <= 1'b1;
        por <= with_por;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        por <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        por <= 1'b0;
        #1;
        rd_chk("pmc reset", ADDR_POWER_MONITOR_CONTROL, PMC_RESET);
        rd_chk("spsc reset", ADDR_STOP_POWER_STATUS_CONTROL, SPSC_RESET);
        chk("active at reset", 8'h01, {7'h00, detect_active});
        $display("test reset values done");

        wr(ADDR_POWER_MONITOR_CONTROL, 8'h3D);
        rd_chk("pmc first write", ADDR_POWER_MONITOR_CONTROL, 8'h3D);
        chk("bandgap on", 8'h01, {7'h00, bandgap_buf_en});
        wr(ADDR_POWER_MONITOR_CONTROL, 8'h00);
        rd_chk("pmc locked", ADDR_POWER_MONITOR_CONTROL, 8'h14);
        chk("bandgap off", 8'h00, {7'h00, bandgap_buf_en});
        $display("test write once done");

        @(posedge core_clk);
        stop_active <= 1'b1;
        tick(2);
        chk("active stop off", 8'h00, {7'h00, detect_active});
        wr(ADDR_POWER_MONITOR_CONTROL, 8'h08);
        chk("active stop on", 8'h01, {7'h00, detect_active});
        @(posedge core_clk);
        stop_active <= 1'b0;
        detect_cmp <= 1'b1;
        for (int i = 0; i < 12 && detect_reset_req !== 1'b1; i++) tick(1);
        chk("reset request", 8'h01, {7'h00, detect_reset_req});
        if (detect_reset_req !== 1'b1) stop_test();
        @(posedge core_clk);
        detect_cmp <= 1'b0;
        tick(6);
        chk("reset request gone", 8'h00, {7'h00, detect_reset_req});
        do_reset(1'b0);
        wr(ADDR_POWER_MONITOR_CONTROL, 8'h00);
        @(posedge core_clk);
        detect_cmp <= 1'b1;
        tick(6);
        chk("no reset disabled", 8'h00, {7'h00, detect_reset_req});
        chk("inactive disabled", 8'h00, {7'h00, detect_active});
        @(posedge core_clk);
        detect_cmp <= 1'b0;
        $display("test detect done");

        warn_cmp <= 1'b1;
        tick(5);
        rd_chk("flag set", ADDR_POWER_MONITOR_CONTROL, 8'h80);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(ADDR_POWER_MONITOR_CONTROL, 8'h20);
        chk("irq raised", 8'h01, {7'h00, irq});
        wr(ADDR_POWER_MONITOR_CONTROL, 8'h60);
        rd_chk("ack refused", ADDR_POWER_MONITOR_CONTROL, 8'hA0);
        @(posedge core_clk);
        warn_cmp <= 1'b0;
        tick(5);
        rd_chk("flag sticky", ADDR_POWER_MONITOR_CONTROL, 8'hA0);
        wr(ADDR_POWER_MONITOR_CONTROL, 8'h60);
        rd_chk("ack taken", ADDR_POWER_MONITOR_CONTROL, 8'h20);
        chk("irq cleared", 8'h00, {7'h00, irq});
        $display("test warning done");

        @(posedge core_clk);
        warn_cmp <= 1'b1;
        do_reset(1'b0);
        tick(4);
        rd_chk("flag after reset", ADDR_POWER_MONITOR_CONTROL, 8'h9C);
        @(posedge core_clk);
        warn_cmp <= 1'b0;
        $display("test warning after reset done");

        wr(ADDR_STOP_POWER_STATUS_CONTROL, 8'h00);
        chk("code 00", 8'h00, {6'h00, trip_code});
        wr(ADDR_STOP_POWER_STATUS_CONTROL, 8'h10);
        chk("code 01", 8'h01, {6'h00, trip_code});
        do_reset(1'b0);
        wr(ADDR_STOP_POWER_STATUS_CONTROL, 8'h20);
        chk("vsel held", 8'h00, {6'h00, trip_code});
        do_reset(1'b1);
        wr(ADDR_STOP_POWER_STATUS_CONTROL, 8'h31);
        chk("code 11", 8'h03, {6'h00, trip_code});
        chk("stop2 chosen", 8'h01, {7'h00, stop2_select});
        wr(ADDR_STOP_POWER_STATUS_CONTROL, 8'h00);
        rd_chk("spsc locked", ADDR_STOP_POWER_STATUS_CONTROL, 8'h21);
        chk("code 10", 8'h02, {6'h00, trip_code});
        chk("stop2 held", 8'h01, {7'h00, stop2_select});
        $display("test stop control done");

        @(posedge core_clk);
        stop2_recovered <= 1'b1;
        @(posedge core_clk);
        stop2_recovered <= 1'b0;
        rd_chk("ppd flag set", ADDR_STOP_POWER_STATUS_CONTROL, 8'h29);
        wr(ADDR_STOP_POWER_STATUS_CONTROL, 8'h24);
        rd_chk("ppd flag cleared", ADDR_STOP_POWER_STATUS_CONTROL, 8'h21);
        $display("test partial power down done");
        stop_test();
    end
endmodule
